// ==== dvt_pkg.sv ====
// Shared constants for the DVI transmitter pixel input block
package dvt_pkg;

    // ==========================================================
    // Register map (byte addresses on APB)
    localparam logic [11:0] ADDR_INPUT_MODE = 12'h000;
    localparam logic [11:0] ADDR_DESKEW = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_CP_CTL = 12'h00C;

    // ==========================================================
    // Field positions
    localparam int BIT_BUS_WIDTH = 0;
    localparam int BIT_EDGE = 1;
    localparam int BIT_CLOCK_MODE = 2;
    localparam int BIT_DESKEW_EN = 0;
    localparam int POS_DESKEW_SET = 1;
    localparam int BIT_CTL3 = 0;

    // ==========================================================
    // Reset values
    localparam logic [2:0] RST_INPUT_MODE = 3'h0;
    localparam logic [3:0] RST_DESKEW = 4'h0;
    localparam logic RST_CTL3 = 1'b0;

    // ==========================================================
    // De-skew: one trim step is one system clock cycle
    localparam logic [2:0] DESKEW_DEFAULT = 3'h4;
    localparam int EDGE_DELAY = 4;
    localparam int HIST_DEPTH = 8;
    localparam int WORD_W = 29;

    // ==========================================================
    // Control characters, indexed by {c1, c0}
    localparam logic [9:0] CTRL_CHAR_00 = 10'h354;
    localparam logic [9:0] CTRL_CHAR_01 = 10'h0AB;
    localparam logic [9:0] CTRL_CHAR_10 = 10'h154;
    localparam logic [9:0] CTRL_CHAR_11 = 10'h2AB;

endpackage

// ==== dvt_tmds_enc.sv ====
// One DC-balanced serial channel encoder with running disparity
`timescale 1ns/1ps

module dvt_tmds_enc (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic de,
    input wire logic [7:0] data,
    input wire logic [1:0] ctrl,
    output logic [9:0] q
);
    import dvt_pkg::*;

    logic [9:0] q_reg;
    logic [9:0] q_next;
    logic signed [5:0] cnt_reg;
    logic signed [5:0] cnt_next;

    function automatic logic [3:0] ones8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    always_comb begin
        logic [8:0] qm;
        logic use_xnor;
        logic [3:0] n1d;
        logic signed [5:0] bal;
        q_next = q_reg;
        cnt_next = cnt_reg;
        qm = 9'h000;
        use_xnor = 1'b0;
        bal = 6'sd0;
        n1d = ones8(data);
        use_xnor = (n1d > 4'h4) || (n1d == 4'h4 && !data[0]);
        qm[0] = data[0];
        for (int i = 1; i < 8; i++) begin
            qm[i] = use_xnor ? ~(qm[i-1] ^ data[i]) : (qm[i-1] ^ data[i]);
        end
        qm[8] = ~use_xnor;
        // Ones minus zeros of the eight payload bits
        bal = $signed({2'h0, ones8(qm[7:0])}) * 6'sd2 - 6'sd8;
        if (load) begin
            if (!de) begin
                cnt_next = 6'sd0;
                case (ctrl)
                    2'h0: q_next = CTRL_CHAR_00;
                    2'h1: q_next = CTRL_CHAR_01;
                    2'h2: q_next = CTRL_CHAR_10;
                    default: q_next = CTRL_CHAR_11;
                endcase
            end else if (cnt_reg == 6'sd0 || bal == 6'sd0) begin
                q_next = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
                cnt_next = qm[8] ? cnt_reg + bal : cnt_reg - bal;
            end else if ((cnt_reg > 6'sd0 && bal > 6'sd0) || (cnt_reg < 6'sd0 && bal < 6'sd0)) begin
                q_next = {1'b1, qm[8], ~qm[7:0]};
                cnt_next = cnt_reg + (qm[8] ? 6'sd2 : 6'sd0) - bal;
            end else begin
                q_next = {1'b0, qm[8], qm[7:0]};
                cnt_next = cnt_reg - (qm[8] ? 6'sd0 : 6'sd2) + bal;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= CTRL_CHAR_00;
            cnt_reg <= 6'sd0;
        end else begin
            q_reg <= q_next;
            cnt_reg <= cnt_next;
        end
    end

    assign q = q_reg;
endmodule

// ==== dvt_pixel_in.sv ====
// Pixel input capture, de-skew, channel mapping and APB configuration
`timescale 1ns/1ps

// What this block does
// - Bus-width select 0 gives 12-bit dual-edge input, 1 gives 24-bit single-edge.
// - Narrow mode latches a 12-bit half-word on both pixel clock edges.
// - Wide mode latches 24 bits once: rising if edge select 1, else falling.
// - Narrow mode edge select picks the primary edge; other edge takes second half.
// - Differential mode uses the clock pair crossover as sampling reference.
// - Low swing: narrow 0 means differential; wide 1 means differential.
// - Differential clocking only possible in low-swing mode.
// - High swing ignores clock-mode select and always uses single-ended clock.
// - Active video: bits 23..16 red on channel 2, 15..8 green ch1, 7..0 blue ch0.
// - Blanking: syncs on channel 0, control 1 on ch1, control 3..2 on ch2.
// - Each encoder picks one of two characters using a running disparity count.
// - The three control bits are encoded and sent in vertical blanking.
// - Top control bit made internally; lower two inputs are reserved pass-through.
// - Serial config select 1 takes selects from registers, 0 from pins.
// - De-skew enable and 3-bit setting move data sampling against the clock.
// - Enabled shift is setting minus 4 steps; disabled uses a default shift.
// - Narrow halves: first blue and green 3..0, second green 7..4 and red.
module dvt_pixel_in (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic input_pixel_clock_pair_p,
    input wire logic input_pixel_clock_pair_n,
    input wire logic [23:0] pixel_data,
    input wire logic data_enable,
    input wire logic hsync,
    input wire logic vsync,
    input wire logic [2:1] blanking_control_bits,
    input wire logic low_swing,
    input wire logic serial_config_select,
    input wire logic bus_width_select,
    input wire logic edge_select,
    input wire logic clock_mode_select,
    input wire logic deskew_enable,
    input wire logic [2:0] deskew_setting,
    output logic [9:0] serial_channel_0,
    output logic [9:0] serial_channel_1,
    output logic [9:0] serial_channel_2,
    output logic char_strobe
);
    import dvt_pkg::*;

    // ==========================================================
    // Two-flop synchronisers for every pin except clk, rst_n and the APB bus
    localparam int PIN_W = 2 + WORD_W + 9;
    logic [PIN_W-1:0] pin_s1_reg;
    logic [PIN_W-1:0] pin_s2_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= {input_pixel_clock_pair_p, input_pixel_clock_pair_n, blanking_control_bits,
                           vsync, hsync, data_enable, pixel_data, low_swing, serial_config_select,
                           bus_width_select, edge_select, clock_mode_select, deskew_enable, deskew_setting};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    logic ck_p, ck_n, sw_low, ser_sel, pin_bw, pin_edge, pin_cm, pin_dk_en;
    logic [2:0] pin_dk_set;
    logic [WORD_W-1:0] word_s;
    assign {ck_p, ck_n, word_s, sw_low, ser_sel, pin_bw, pin_edge, pin_cm, pin_dk_en, pin_dk_set} = pin_s2_reg;

    // ==========================================================
    // APB registers
    logic [2:0] mode_reg, mode_next;
    logic [3:0] dk_reg, dk_next;
    logic ctl3_reg, ctl3_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [2:0] cfg_reg, cfg_next;
    logic half_reg, half_next;
    logic diff_mode;

    always_comb begin
        mode_next = mode_reg;
        dk_next = dk_reg;
        ctl3_next = ctl3_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        prdata_next = 32'h0000_0000;
        if (psel && !penable) begin
            // Answer in the first access cycle, never waits
            pready_next = 1'b1;
            if (paddr == ADDR_INPUT_MODE) begin
                prdata_next = {29'h0, mode_reg};
            end else if (paddr == ADDR_DESKEW) begin
                prdata_next = {28'h0, dk_reg};
            end else if (paddr == ADDR_STATUS) begin
                prdata_next = {26'h0, half_reg, diff_mode, sw_low, cfg_reg};
            end else if (paddr == ADDR_CP_CTL) begin
                prdata_next = {31'h0, ctl3_reg};
            end else begin
                pslverr_next = 1'b1;
            end
        end
        if (psel && penable && pready_reg && pwrite) begin
            if (paddr == ADDR_INPUT_MODE) begin
                mode_next = pwdata[2:0];
            end else if (paddr == ADDR_DESKEW) begin
                dk_next = pwdata[3:0];
            end else if (paddr == ADDR_CP_CTL) begin
                ctl3_next = pwdata[BIT_CTL3];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= RST_INPUT_MODE;
            dk_reg <= RST_DESKEW;
            ctl3_reg <= RST_CTL3;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            mode_reg <= mode_next;
            dk_reg <= dk_next;
            ctl3_reg <= ctl3_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    // ==========================================================
    // Effective configuration
    logic [2:0] cfg_req;
    logic dk_on;
    logic [2:0] dk_set;
    assign cfg_req = ser_sel ? mode_reg : {pin_cm, pin_edge, pin_bw};
    assign dk_on = ser_sel ? dk_reg[BIT_DESKEW_EN] : pin_dk_en;
    assign dk_set = ser_sel ? dk_reg[POS_DESKEW_SET +: 3] : pin_dk_set;

    // Low swing: sense flips with bus width; high swing never differential
    assign diff_mode = sw_low && (cfg_reg[BIT_BUS_WIDTH] ? cfg_reg[BIT_CLOCK_MODE]
                                                         : !cfg_reg[BIT_CLOCK_MODE]);

    // ==========================================================
    // Clock edge detection, delayed so that data may be taken early or late
    logic ck_lvl;
    logic ck_prev_reg, ck_prev_next;
    logic [EDGE_DELAY-1:0] rise_dly_reg, rise_dly_next;
    logic [EDGE_DELAY-1:0] fall_dly_reg, fall_dly_next;
    logic [WORD_W-1:0] hist_reg [HIST_DEPTH];
    logic [WORD_W-1:0] hist_next [HIST_DEPTH];

    // Crossover as comparator of the pair; single-ended uses the plus line
    assign ck_lvl = diff_mode ? (ck_p && !ck_n) : ck_p;

    always_comb begin
        ck_prev_next = ck_lvl;
        rise_dly_next = {rise_dly_reg[EDGE_DELAY-2:0], ck_lvl && !ck_prev_reg};
        fall_dly_next = {fall_dly_reg[EDGE_DELAY-2:0], !ck_lvl && ck_prev_reg};
        hist_next[0] = word_s;
        for (int i = 1; i < HIST_DEPTH; i++) begin
            hist_next[i] = hist_reg[i-1];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_prev_reg <= 1'b0;
            rise_dly_reg <= '0;
            fall_dly_reg <= '0;
            for (int i = 0; i < HIST_DEPTH; i++) begin
                hist_reg[i] <= '0;
            end
        end else begin
            ck_prev_reg <= ck_prev_next;
            rise_dly_reg <= rise_dly_next;
            fall_dly_reg <= fall_dly_next;
            for (int i = 0; i < HIST_DEPTH; i++) begin
                hist_reg[i] <= hist_next[i];
            end
        end
    end

    // Entry 3 lines up with the delayed edge; older entries mean earlier sampling
    logic [2:0] tap_idx;
    logic [WORD_W-1:0] tap;
    assign tap_idx = 3'h7 - (dk_on ? dk_set : DESKEW_DEFAULT);
    assign tap = hist_reg[tap_idx];

    // ==========================================================
    // Capture and pixel assembly
    logic rise_ev, fall_ev, prim_ev, sec_ev;
    logic [16:0] low_reg, low_next;
    logic pix_valid_reg, pix_valid_next;
    logic [23:0] pix_reg, pix_next;
    logic pix_de_reg, pix_de_next;
    logic [1:0] pix_sync_reg, pix_sync_next;
    logic [2:1] pix_ctl_reg, pix_ctl_next;
    logic strobe_reg;

    assign rise_ev = rise_dly_reg[EDGE_DELAY-1];
    assign fall_ev = fall_dly_reg[EDGE_DELAY-1];
    assign prim_ev = cfg_reg[BIT_EDGE] ? rise_ev : fall_ev;
    assign sec_ev = cfg_reg[BIT_EDGE] ? fall_ev : rise_ev;

    always_comb begin
        cfg_next = cfg_reg;
        half_next = half_reg;
        low_next = low_reg;
        pix_valid_next = 1'b0;
        pix_next = pix_reg;
        pix_de_next = pix_de_reg;
        pix_sync_next = pix_sync_reg;
        pix_ctl_next = pix_ctl_reg;
        // Only while no half-word is held and no delayed edge fires this cycle
        if (!half_reg && !rise_ev && !fall_ev) begin
            cfg_next = cfg_req;
        end
        if (cfg_reg[BIT_BUS_WIDTH]) begin
            half_next = 1'b0;
            if (prim_ev) begin
                pix_valid_next = 1'b1;
                pix_next = tap[23:0];
                {pix_ctl_next, pix_sync_next[1], pix_sync_next[0], pix_de_next} = tap[28:24];
            end
        end else if (prim_ev) begin
            half_next = 1'b1;
            low_next = {tap[28:24], tap[11:0]};
        end else if (sec_ev && half_reg) begin
            half_next = 1'b0;
            pix_valid_next = 1'b1;
            pix_next = {tap[11:4], tap[3:0], low_reg[11:8], low_reg[7:0]};
            {pix_ctl_next, pix_sync_next[1], pix_sync_next[0], pix_de_next} = low_reg[16:12];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= RST_INPUT_MODE;
            half_reg <= 1'b0;
            low_reg <= '0;
            pix_valid_reg <= 1'b0;
            pix_reg <= 24'h00_0000;
            pix_de_reg <= 1'b0;
            pix_sync_reg <= 2'h0;
            pix_ctl_reg <= 2'h0;
            strobe_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            half_reg <= half_next;
            low_reg <= low_next;
            pix_valid_reg <= pix_valid_next;
            pix_reg <= pix_next;
            pix_de_reg <= pix_de_next;
            pix_sync_reg <= pix_sync_next;
            pix_ctl_reg <= pix_ctl_next;
            strobe_reg <= pix_valid_reg;
        end
    end

    assign char_strobe = strobe_reg;

    // ==========================================================
    // Channel mapping; control bits only carried while vsync is asserted
    logic vblank;
    logic [1:0] c0, c1, c2;
    assign vblank = pix_sync_reg[1];
    assign c0 = pix_sync_reg;
    assign c1 = {1'b0, vblank && pix_ctl_reg[1]};
    assign c2 = {vblank && ctl3_reg, vblank && pix_ctl_reg[2]};

    dvt_tmds_enc u_enc0 (
        .clk(clk),
        .rst_n(rst_n),
        .load(pix_valid_reg),
        .de(pix_de_reg),
        .data(pix_reg[7:0]),
        .ctrl(c0),
        .q(serial_channel_0)
    );

    dvt_tmds_enc u_enc1 (
        .clk(clk),
        .rst_n(rst_n),
        .load(pix_valid_reg),
        .de(pix_de_reg),
        .data(pix_reg[15:8]),
        .ctrl(c1),
        .q(serial_channel_1)
    );

    dvt_tmds_enc u_enc2 (
        .clk(clk),
        .rst_n(rst_n),
        .load(pix_valid_reg),
        .de(pix_de_reg),
        .data(pix_reg[23:16]),
        .ctrl(c2),
        .q(serial_channel_2)
    );
endmodule

// ==== dvt_pixel_in_sva.sv ====
// Assertion checker for the pixel input block
`timescale 1ns/1ps

module dvt_pixel_in_sva
    import dvt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [9:0] serial_channel_0,
    input wire logic [9:0] serial_channel_1,
    input wire logic [9:0] serial_channel_2,
    input wire logic char_strobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ====
    // Running disparity of channel 0, in half units
    logic signed [7:0] disp_reg, disp_next;

    function automatic logic is_ctl(input logic [9:0] q);
        return q == CTRL_CHAR_00 || q == CTRL_CHAR_01 || q == CTRL_CHAR_10 || q == CTRL_CHAR_11;
    endfunction

    always_comb begin
        disp_next = disp_reg;
        if (char_strobe) begin
            disp_next = is_ctl(serial_channel_0) ? 8'sh0 : disp_reg + 8'($countones(serial_channel_0)) - 8'sh5;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            disp_reg <= 8'sh0;
        end else begin
            disp_reg <= disp_next;
        end
    end

    // ====
    // Properties
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_answer;
        psel && penable && pready;
    endsequence

    chk_ready_setup: assert property (apb_setup |=> apb_answer)
        else $error("no ready after setup");
    chk_ready_access: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
        else $error("ready outside access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    chk_err_clean: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error with data");
    chk_strobe_gap: assert property (char_strobe |=> !char_strobe [*8])
        else $error("pixels too close");
    chk_chars_hold: assert property (!char_strobe && !$past(char_strobe) |-> $stable(serial_channel_0)
        && $stable(serial_channel_1) && $stable(serial_channel_2))
        else $error("characters moved");
    chk_blank_chars: assert property (char_strobe && is_ctl(serial_channel_0) |-> is_ctl(serial_channel_2)
        && (serial_channel_1 == CTRL_CHAR_00 || serial_channel_1 == CTRL_CHAR_01))
        else $error("mixed blanking");
    chk_disp_bound: assert property (disp_reg <= 8'sd16 && disp_reg >= -8'sd16)
        else $error("disparity runaway");
endmodule

bind dvt_pixel_in dvt_pixel_in_sva i_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_channel_0(serial_channel_0),
    .serial_channel_1(serial_channel_1), .serial_channel_2(serial_channel_2), .char_strobe(char_strobe));

// ==== dvt_gfx_model.sv ====
// Behavioural graphics controller driving the pixel bus
`timescale 1ns/1ps

module dvt_gfx_model (
    input wire logic edge_rise,
    input wire logic wide,
    input wire logic diff,
    output logic clk_p,
    output logic clk_n,
    output logic [23:0] data,
    output logic de,
    output logic hs,
    output logic vs,
    output logic [2:1] ctl
);
    // Single-ended source ties the minus leg low
    assign clk_n = diff ? ~clk_p : 1'b0;

    initial begin
        clk_p = 1'b0;
        data = 24'h0;
        {de, vs, hs, ctl} = 5'h0;
    end

    // Clock stands at the level just before the primary edge
    // Edge sense comes as an argument: the port may not have settled yet
    task automatic park(input logic rise);
        clk_p = ~rise;
    endtask

    // 125 ns period; data valid 20 ns before to 40 ns after an edge, inverted otherwise
    task automatic pixel(input logic [23:0] rgb, input logic [4:0] c);
        {de, vs, hs, ctl} = c;
        data = rgb;
        #20 clk_p = ~clk_p;
        #40 data = ~data;
        #2.5 data = wide ? data : {rgb[11:0], rgb[23:12]};
        #20 clk_p = ~clk_p;
        #40 data = ~data;
        #2.5;
    endtask
endmodule

// ==== dvt_pixel_in_tb.sv ====
// Self-checking bench for the pixel input block
`timescale 1ns/1ps

module dvt_pixel_in_tb;
    import dvt_pkg::*;

    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, char_strobe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pix_p, pix_n, de, hs, vs, ls, cfg_sel, bw, edge_s, cm, dk_en;
    logic [23:0] pdata;
    logic [2:1] ctl;
    logic [2:0] dk_set;
    logic [9:0] ch0, ch1, ch2;
    logic hold, g_wide, g_edge, g_diff, cp3;
    logic [29:0] expq[$];
    int fail_count, total_checks;

    dvt_pixel_in i_dvt_pixel_in (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .input_pixel_clock_pair_p(pix_p), .input_pixel_clock_pair_n(pix_n), .pixel_data(pdata),
        .data_enable(de), .hsync(hs), .vsync(vs), .blanking_control_bits(ctl), .low_swing(ls),
        .serial_config_select(cfg_sel), .bus_width_select(bw), .edge_select(edge_s),
        .clock_mode_select(cm), .deskew_enable(dk_en), .deskew_setting(dk_set), .serial_channel_0(ch0),
        .serial_channel_1(ch1), .serial_channel_2(ch2), .char_strobe(char_strobe));

    dvt_gfx_model i_dvt_gfx_model (.edge_rise(g_edge), .wide(g_wide), .diff(g_diff), .clk_p(pix_p),
        .clk_n(pix_n), .data(pdata), .de(de), .hs(hs), .vs(vs), .ctl(ctl));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ====
    // Reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ====
    // Register bus
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
                       output logic [31:0] d, output logic e);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            test_done;
        end else begin
            d = prdata;
            e = pslverr;
            {psel, penable} <= 2'b00;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, v, d, e);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        check(d, x);
        check(32'(e), 32'(xe));
    endtask

    // ====
    // Pixel model
    function automatic logic [7:0] dec(input logic [9:0] q);
        logic [7:0] d;
        logic [7:0] b;
        d = q[9] ? ~q[7:0] : q[7:0];
        b[0] = d[0];
        for (int i = 1; i < 8; i++) b[i] = d[i] ^ d[i - 1] ^ !q[8];
        return b;
    endfunction

    function automatic logic [9:0] cc(input logic [1:0] s);
        case (s)
            2'b00: return CTRL_CHAR_00;
            2'b01: return CTRL_CHAR_01;
            2'b10: return CTRL_CHAR_10;
            default: return CTRL_CHAR_11;
        endcase
    endfunction

    always @(posedge clk) begin
        logic [29:0] x;
        if (rst_n === 1'b1 && char_strobe === 1'b1 && !hold) begin
            if (expq.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                x = expq.pop_front();
                if (x[29]) check(32'({dec(ch2), dec(ch1), dec(ch0)}), 32'(x[23:0]));
                else check(32'({ch2, ch1, ch0}), 32'({cc(x[26:25]), cc({1'b0, x[24]}), cc(x[28:27])}));
            end
        end
    end

    // Strobes from the reconfiguration edge are not pixels
    task automatic setup(input logic w, input logic ed, input logic c, input logic l, input logic viareg);
        hold = 1'b1;
        {g_wide, g_edge, g_diff} = {w, ed, l & (w ~^ c)};
        ls <= l;
        cfg_sel <= viareg;
        {cm, edge_s, bw} <= viareg ? ~{c, ed, w} : {c, ed, w};
        if (viareg) wr(ADDR_INPUT_MODE, 32'({c, ed, w}));
        i_dvt_gfx_model.park(ed);
        repeat (30) @(posedge clk);
        expq.delete();
        hold = 1'b0;
    endtask

    task automatic burst(input int n);
        logic [23:0] rgb;
        logic [4:0] c;
        c = {1'b1, 4'($urandom)};
        for (int i = 0; i < n; i++) begin
            rgb = 24'($urandom);
            if (i >= n - 2) c = {1'b0, i == n - 2 || 1'($urandom), 3'($urandom)};
            expq.push_back({c[4:2], c[3] & cp3, c[1:0] & {2{c[3]}}, rgb});
            i_dvt_gfx_model.pixel(rgb, c);
        end
        repeat (30) @(posedge clk);
        check(32'(expq.size()), 32'h0);
    endtask

    initial begin
        logic [3:0] mv;
        logic [31:0] d;
        logic e;
        void'($urandom(89165));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ls, cfg_sel, bw, edge_s, cm, dk_en, dk_set, g_wide, g_edge, g_diff, cp3} = '0;
        hold = 1'b1;
        rst_n = 1'b0;
        fail_count = 0;
        total_checks = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(ADDR_INPUT_MODE, 32'(RST_INPUT_MODE), 1'b0);
        rdchk(ADDR_DESKEW, 32'(RST_DESKEW), 1'b0);
        rdchk(ADDR_CP_CTL, 32'(RST_CTL3), 1'b0);
        wr(12'h010, 32'hFFFFFFFF);
        rdchk(12'h010, 32'h0, 1'b1);
        wr(ADDR_DESKEW, 32'hFFFFFFFF);
        rdchk(ADDR_DESKEW, 32'hF, 1'b0);
        wr(ADDR_DESKEW, 32'h0);
        for (int m = 0; m < 16; m++) begin
            mv = 4'(m);
            {ls, cm, edge_s, bw} <= mv;
            repeat (6) @(posedge clk);
            apb(1'b0, ADDR_STATUS, 32'h0, d, e);
            check(32'(d[2:0]), 32'(mv[2:0]));
            check(32'(d[4:3]), 32'({mv[3] & (mv[0] ~^ mv[2]), mv[3]}));
        end
        for (int m = 0; m < 6; m++) begin
            mv = 4'(m);
            cp3 = mv[0];
            wr(ADDR_CP_CTL, 32'(cp3));
            setup(mv[0], mv[1], m < 4 ? mv[0] : 1'($urandom), m < 4, m >= 4);
            burst(10);
        end
        // Early sampling sees the word before each edge: the idle word after a gap, else the inverted bus
        setup(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        wr(ADDR_DESKEW, 32'h1);
        hold = 1'b1;
        i_dvt_gfx_model.pixel(24'h5A3C96, 5'h10);
        repeat (30) @(posedge clk);
        expq.delete();
        hold = 1'b0;
        for (int i = 0; i < 6; i++) begin
            if (i == 3) wr(ADDR_DESKEW, 32'hD);
            expq.push_back({6'h20, (i == 0 || i >= 3) ? 24'h5A3C96 : 24'hA5C369});
            i_dvt_gfx_model.pixel(24'h5A3C96, 5'h10);
        end
        repeat (30) @(posedge clk);
        check(32'(expq.size()), 32'h0);
        test_done;
    end
endmodule
